// [design/pld_edge_meter.sv]
// Measures the spacing of reference and feedback rising edges.
// Assumes both inputs are already synchronised levels on i_clk.
`timescale 1ns/1ps
`default_nettype none
module pld_edge_meter #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Synchronised edge levels
    input wire logic i_ref,
    input wire logic i_fb,
    // Reference rising edge strobe and per detector cycle result
    output logic o_ref_rise,
    output logic o_done,
    output logic [CNT_W-1:0] o_diff
);
    typedef struct packed {
        logic ref_q;
        logic fb_q;
        logic pend;
        logic pend_ref;
        logic [CNT_W-1:0] cnt;
        logic done;
        logic [CNT_W-1:0] diff;
    } pld_meter_type;

    pld_meter_type q;
    pld_meter_type n;
    logic rr;
    logic fr;

    // First edge opens a cycle, the other edge closes it
    always_comb begin
        n = q;
        rr = i_ref && !q.ref_q;
        fr = i_fb && !q.fb_q;
        n.ref_q = i_ref;
        n.fb_q = i_fb;
        n.done = 1'b0;
        if (rr && fr) begin
            n.done = 1'b1;
            n.diff = '0;
            n.pend = 1'b0;
        end else if (q.pend) begin
            if (q.pend_ref ? fr : rr) begin
                n.done = 1'b1;
                n.diff = q.cnt;
                n.pend = 1'b0;
            end else if (q.pend_ref ? rr : fr) begin
                // A missing partner edge counts as a wide cycle
                n.done = 1'b1;
                n.diff = '1;
                n.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (q.cnt != '1) begin
                n.cnt = q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end else if (rr || fr) begin
            n.pend = 1'b1;
            n.pend_ref = rr;
            n.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_ref_rise = rr;
    assign o_done = q.done;
    assign o_diff = q.diff;
endmodule
`default_nettype wire

// [design/pld_lock_cal_ctrl.sv]
// Digital lock detector and calibration clock control, AXI4-Lite slave.
// Assumes reference and feedback edge pins asynchronous to i_clk.
// Operation
// - Lock is declared only after 5, 16, 64 or 255 straight good cycles.
// - A cycle is good when the edge spacing is below the lock window.
// - Once locked, the flag holds until spacing exceeds the loss limit or detection is disabled.
// - Window select bit 0 picks the high range (reset), 1 the low range.
// - Disable bit 0 runs detection (reset), 1 turns detection off.
// - Calibration clock is the reference divided by 2, 4, 8 or 16.
`timescale 1ns/1ps
`default_nettype none
module pld_lock_cal_ctrl #(
    parameter logic [7:0] WIN_HI = pld_pkg::WIN_HI_CYC,
    parameter logic [7:0] WIN_LO = pld_pkg::WIN_LO_CYC,
    parameter logic [7:0] LOSS_HI = pld_pkg::LOSS_HI_CYC,
    parameter logic [7:0] LOSS_LO = pld_pkg::LOSS_LO_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [pld_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [pld_pkg::ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Phase detector edge pins
    input wire logic i_ref_pin,
    input wire logic i_fb_pin,
    // Block outputs
    output logic o_digital_lock_indicator,
    output logic o_cal_clk,
    output logic o_cal_start,
    output logic o_irq
);
    typedef struct packed {
        logic awrdy;
        logic aw_ok;
        logic [pld_pkg::ADDR_W-1:0] awaddr;
        logic wrdy;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl;
        logic [7:0] run_cnt;
        logic locked;
        logic [pld_pkg::NUM_EV-1:0] sts;
        logic [pld_pkg::NUM_EV-1:0] ien;
        logic irq;
        logic cal_pulse;
        logic [2:0] div_cnt;
        logic cal_clk;
    } pld_state_type;

    pld_state_type q;
    pld_state_type n;
    logic [pld_pkg::NUM_EV-1:0] ev;
    logic [7:0] win;
    logic [7:0] loss;
    logic [7:0] need;
    logic ref_lvl;
    logic fb_lvl;
    logic m_ref_rise;
    logic m_done;
    logic [7:0] m_diff;

    // Good-cycle count needed for each counter select code
    function automatic logic [7:0] need_count(input logic [1:0] sel);
        case (sel)
            2'h0: need_count = pld_pkg::NEED_C0;
            2'h1: need_count = pld_pkg::NEED_C1;
            2'h2: need_count = pld_pkg::NEED_C2;
            default: need_count = pld_pkg::NEED_C3;
        endcase
    endfunction

    // Last reference edge index of each half calibration period
    function automatic logic [2:0] div_last(input logic [1:0] code);
        case (code)
            2'h0: div_last = 3'h0;
            2'h1: div_last = 3'h1;
            2'h2: div_last = 3'h3;
            default: div_last = 3'h7;
        endcase
    endfunction

    // Pins are asynchronous, so both pass the three-stage filter
    pld_sync3 u_sync_ref (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_ref_pin),
        .o_level(ref_lvl)
    );

    pld_sync3 u_sync_fb (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_fb_pin),
        .o_level(fb_lvl)
    );

    pld_edge_meter #(
        .CNT_W(8)
    ) u_meter (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ref(ref_lvl),
        .i_fb(fb_lvl),
        .o_ref_rise(m_ref_rise),
        .o_done(m_done),
        .o_diff(m_diff)
    );

    // Window and loss limits follow the range select bit
    assign win = q.ctrl[pld_pkg::WIN_BIT] ? WIN_LO : WIN_HI;
    assign loss = q.ctrl[pld_pkg::WIN_BIT] ? LOSS_LO : LOSS_HI;
    assign need = need_count(q.ctrl[pld_pkg::CNT_SEL_LSB +: 2]);

    // Next state: bus slave, lock detector, divider, interrupts
    always_comb begin
        n = q;
        ev = '0;
        n.cal_pulse = 1'b0;
        // Address and data are taken in either order
        if (i_awvalid && q.awrdy) begin
            n.aw_ok = 1'b1;
            n.awaddr = i_awaddr;
        end
        if (i_wvalid && q.wrdy) begin
            n.w_ok = 1'b1;
            n.wdata = i_wdata;
            n.wstrb = i_wstrb;
        end
        if (q.aw_ok && q.w_ok && !q.bvalid) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = pld_pkg::RESP_OKAY;
            case (q.awaddr)
                pld_pkg::CTRL_OFS: begin
                    if (q.wstrb[0]) begin
                        n.ctrl = q.wdata[7:0];
                        // Only a 0 to 1 step of the start bit counts
                        if (!q.ctrl[pld_pkg::CAL_BIT] &&
                            q.wdata[pld_pkg::CAL_BIT]) begin
                            n.cal_pulse = 1'b1;
                            ev[pld_pkg::EV_CAL] = 1'b1;
                        end
                    end
                end
                pld_pkg::STATUS_OFS, pld_pkg::IRQ_STS_OFS: begin
                    n.bresp = pld_pkg::RESP_OKAY;
                end
                pld_pkg::IRQ_EN_OFS: begin
                    if (q.wstrb[0]) begin
                        n.ien = q.wdata[pld_pkg::NUM_EV-1:0];
                    end
                end
                pld_pkg::IRQ_CLR_OFS: begin
                    if (q.wstrb[0]) begin
                        n.sts = q.sts & ~q.wdata[pld_pkg::NUM_EV-1:0];
                    end
                end
                default: begin
                    n.bresp = pld_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && i_bready) begin
            n.bvalid = 1'b0;
        end
        // Reads answer one cycle after the address is taken
        if (i_arvalid && q.arrdy) begin
            n.rvalid = 1'b1;
            n.rresp = pld_pkg::RESP_OKAY;
            n.rdata = 32'h0;
            case (i_araddr)
                pld_pkg::CTRL_OFS: begin
                    n.rdata[7:0] = q.ctrl;
                end
                pld_pkg::STATUS_OFS: begin
                    n.rdata[pld_pkg::STS_LOCK_BIT] = q.locked;
                    n.rdata[pld_pkg::STS_RUN_LSB +: 8] = q.run_cnt;
                end
                pld_pkg::IRQ_STS_OFS: begin
                    n.rdata[pld_pkg::NUM_EV-1:0] = q.sts;
                end
                pld_pkg::IRQ_EN_OFS: begin
                    n.rdata[pld_pkg::NUM_EV-1:0] = q.ien;
                end
                pld_pkg::IRQ_CLR_OFS: begin
                    n.rresp = pld_pkg::RESP_OKAY;
                end
                default: begin
                    n.rresp = pld_pkg::RESP_SLVERR;
                end
            endcase
        end else if (q.rvalid && i_rready) begin
            n.rvalid = 1'b0;
        end
        n.awrdy = !n.aw_ok;
        n.wrdy = !n.w_ok;
        n.arrdy = !n.rvalid;
        // Lock detector, evaluated once per detector cycle
        if (q.ctrl[pld_pkg::DIS_BIT]) begin
            n.locked = 1'b0;
            n.run_cnt = 8'h00;
            ev[pld_pkg::EV_LOSS] = q.locked;
        end else if (m_done) begin
            if (!q.locked) begin
                if (m_diff < win) begin
                    // Compare with >= so a smaller count select still locks
                    if (q.run_cnt >= need - 8'h01) begin
                        n.locked = 1'b1;
                        n.run_cnt = need;
                        ev[pld_pkg::EV_LOCK] = 1'b1;
                    end else begin
                        n.run_cnt = q.run_cnt + 8'h01;
                    end
                end else begin
                    n.run_cnt = 8'h00;
                end
            end else if (m_diff > loss) begin
                n.locked = 1'b0;
                n.run_cnt = 8'h00;
                ev[pld_pkg::EV_LOSS] = 1'b1;
            end
        end
        // Calibration clock toggles every half period of reference edges
        if (m_ref_rise) begin
            if (q.div_cnt >= div_last(q.ctrl[pld_pkg::DIV_LSB +: 2])) begin
                n.div_cnt = 3'h0;
                n.cal_clk = !q.cal_clk;
            end else begin
                n.div_cnt = q.div_cnt + 3'h1;
            end
        end
        // Events set after the clear so a same-cycle event is kept
        n.sts = n.sts | ev;
        n.irq = |(n.sts & n.ien);
    end

    // All state in one register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
            q.ctrl <= pld_pkg::CTRL_RST;
            q.awrdy <= 1'b1;
            q.wrdy <= 1'b1;
            q.arrdy <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign o_awready = q.awrdy;
    assign o_wready = q.wrdy;
    assign o_bvalid = q.bvalid;
    assign o_bresp = q.bresp;
    assign o_arready = q.arrdy;
    assign o_rvalid = q.rvalid;
    assign o_rdata = q.rdata;
    assign o_rresp = q.rresp;
    assign o_digital_lock_indicator = q.locked;
    assign o_cal_clk = q.cal_clk;
    assign o_cal_start = q.cal_pulse;
    assign o_irq = q.irq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // Checks on lock, divider and bus behaviour
    AST_LOCK_AFTER_RUN: assert property (
        $rose(q.locked) |->
            $past(q.run_cnt) >= $past(need) - 8'h01
            && q.run_cnt == $past(need))
        else $error("lock set before full run of good cycles");
    AST_LOCK_IN_WINDOW: assert property (
        $rose(q.locked) |-> $past(m_done) && $past(m_diff) < $past(win))
        else $error("lock set without an in-window cycle");
    AST_LOCK_HOLD: assert property (
        q.locked && m_done && m_diff <= loss
            && !q.ctrl[pld_pkg::DIS_BIT] |=> q.locked)
        else $error("lock dropped inside loss threshold");
    AST_LOSS_DROP: assert property (
        q.locked && m_done && m_diff > loss |=> !q.locked ##1 !q.locked)
        else $error("lock kept past loss threshold");
    AST_WIN_RANGE: assert property (
        !q.locked && m_done && !q.ctrl[pld_pkg::DIS_BIT]
            && m_diff >= (q.ctrl[pld_pkg::WIN_BIT] ? WIN_LO : WIN_HI)
            |=> q.run_cnt == 8'h00 && !q.locked)
        else $error("out-of-window cycle counted for selected range");
    AST_DISABLE: assert property (
        q.ctrl[pld_pkg::DIS_BIT] |=> !q.locked && q.run_cnt == 8'h00)
        else $error("lock detection active while disabled");
    AST_CAL_TOGGLE: assert property (
        q.cal_clk != $past(q.cal_clk) |-> $past(m_ref_rise))
        else $error("calibration clock moved without reference edge");
    AST_CAL_START: assert property (
        $rose(q.ctrl[pld_pkg::CAL_BIT]) |-> q.cal_pulse ##1 !q.cal_pulse)
        else $error("start bit rise did not give one start pulse");
    AST_RUN_RESTART: assert property (
        m_done && m_diff >= win && !q.locked |=> q.run_cnt == 8'h00)
        else $error("good-cycle count not restarted");
    AST_BRESP_HOLD: assert property (
        q.bvalid && !i_bready |=> q.bvalid && $stable(q.bresp))
        else $error("write response dropped before bready");
endmodule
`default_nettype wire

// [design/pld_pkg.sv]
// Shared constants for the lock detector and calibration clock block.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package pld_pkg;

    // Register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h18;
    localparam logic [7:0] STATUS_OFS = 8'h1c;
    localparam logic [7:0] IRQ_STS_OFS = 8'h20;
    localparam logic [7:0] IRQ_EN_OFS = 8'h24;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h28;

    // Control register field positions
    localparam int CNT_SEL_LSB = 5;
    localparam int WIN_BIT = 4;
    localparam int DIS_BIT = 3;
    localparam int DIV_LSB = 1;
    localparam int CAL_BIT = 0;
    localparam logic [7:0] CTRL_RST = 8'h06;

    // Status register field positions
    localparam int STS_LOCK_BIT = 0;
    localparam int STS_RUN_LSB = 8;

    // Consecutive in-window detector cycles needed for lock
    localparam logic [7:0] NEED_C0 = 8'h05;
    localparam logic [7:0] NEED_C1 = 8'h10;
    localparam logic [7:0] NEED_C2 = 8'h40;
    localparam logic [7:0] NEED_C3 = 8'hff;

    // Lock window and loss threshold, in system clock cycles
    localparam logic [7:0] WIN_HI_CYC = 8'h06;
    localparam logic [7:0] WIN_LO_CYC = 8'h03;
    localparam logic [7:0] LOSS_HI_CYC = 8'h0c;
    localparam logic [7:0] LOSS_LO_CYC = 8'h06;

    // Interrupt event bits
    localparam int NUM_EV = 3;
    localparam int EV_LOCK = 0;
    localparam int EV_LOSS = 1;
    localparam int EV_CAL = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [design/pld_sync3.sv]
// Three-stage synchroniser for a pin input with a debounced level.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module pld_sync3 (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Pin and clean level
    input wire logic i_pin,
    output logic o_level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } pld_sync_type;

    pld_sync_type q;
    pld_sync_type n;

    // Level changes only once stages two and three agree
    always_comb begin
        n = q;
        n.s1 = i_pin;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.lvl = q.s2;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_level = q.lvl;
endmodule
`default_nettype wire

// [tb/pld_lock_cal_ctrl_tb.sv]
// Self-checking bench for the lock detector and calibration clock block.
// Assumes the bench alone drives the AXI4-Lite port and both edge pins.
`timescale 1ns/1ps
`default_nettype none
module pld_lock_cal_ctrl_tb;
    logic i_clk;
    logic i_reset;
    logic i_awvalid;
    logic i_wvalid;
    logic i_bready;
    logic i_arvalid;
    logic i_rready;
    logic [7:0] i_awaddr;
    logic [7:0] i_araddr;
    logic [31:0] i_wdata;
    logic [3:0] i_wstrb;
    logic i_ref_pin;
    logic i_fb_pin;
    logic o_awready;
    logic o_wready;
    logic o_bvalid;
    logic o_arready;
    logic o_rvalid;
    logic [1:0] o_bresp;
    logic [1:0] o_rresp;
    logic [31:0] o_rdata;
    logic o_digital_lock_indicator;
    logic o_cal_clk;
    logic o_cal_start;
    logic o_irq;
    int n_fail = 0;
    int checked = 0;
    int n_cal = 0;
    int n_start = 0;
    int gap;
    int s0;
    logic cal_prev = 1'b0;
    int need_tab[4] = '{5, 16, 64, 255};

    pld_lock_cal_ctrl i_pld_lock_cal_ctrl (
        .i_clk(i_clk), .i_reset(i_reset),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_rdata(o_rdata), .o_rresp(o_rresp),
        .i_ref_pin(i_ref_pin), .i_fb_pin(i_fb_pin),
        .o_digital_lock_indicator(o_digital_lock_indicator),
        .o_cal_clk(o_cal_clk), .o_cal_start(o_cal_start), .o_irq(o_irq)
    );

    // 50 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // Count calibration clock rises and start pulses, one per cycle
    always @(posedge i_clk) begin
        cal_prev <= o_cal_clk;
        if (o_cal_clk === 1'b1 && cal_prev === 1'b0) n_cal++;
        if (o_cal_start === 1'b1) n_start++;
    end

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    // A missing bus answer ends the run rather than hanging it
    task automatic hang(input string what);
        $display("BAD %s expected answer seen none", what);
        n_fail++;
        wrap_up();
    endtask

    // Write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge i_clk);
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wvalid <= 1'b1;
        i_wdata <= d;
        i_bready <= 1'b1;
        forever begin
            @(posedge i_clk);
            n++;
            if (n > 50) hang("write");
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) begin
                chk("bresp", 32'(er), 32'(o_bresp));
                i_bready <= 1'b0;
                break;
            end
        end
    endtask

    // Read: rready held until rvalid, data compared at that edge
    task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                      input logic [1:0] er, input string what);
        int n;
        n = 0;
        @(posedge i_clk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        forever begin
            @(posedge i_clk);
            n++;
            if (n > 50) hang("read");
            if (o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) begin
                chk(what, ex, o_rdata);
                chk("rresp", 32'(er), 32'(o_rresp));
                i_rready <= 1'b0;
                break;
            end
        end
    endtask

    // One detector cycle: feedback rises d cycles after the reference,
    // or the reference -d cycles after the feedback when d is negative
    task automatic pair(input int d);
        i_ref_pin <= (d >= 0);
        i_fb_pin <= (d <= 0);
        if (d != 0) begin
            repeat (d < 0 ? -d : d) @(posedge i_clk);
            i_ref_pin <= 1'b1;
            i_fb_pin <= 1'b1;
        end
        repeat (4) @(posedge i_clk);
        i_ref_pin <= 1'b0;
        i_fb_pin <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask

    // Random spacings strictly inside the window, either pin leading
    task automatic goods(input int n, input int win);
        repeat (n) pair(int'($urandom_range(2 * win - 2, 0)) - (win - 1));
    endtask

    // Pin synchronisers add latency, so let the result settle first
    task automatic lock_is(input logic exp, input string what);
        repeat (4) @(posedge i_clk);
        chk(what, 32'(exp), 32'(o_digital_lock_indicator));
    endtask

    // Reference-only pulses; gap between the last two cal clock rises
    task automatic cal_gap(input int div, output int g);
        int last;
        int prev;
        int seen;
        seen = n_cal;
        last = -1;
        prev = -1;
        for (int k = 0; k < 3 * div + 2; k++) begin
            i_ref_pin <= 1'b1;
            repeat (4) @(posedge i_clk);
            i_ref_pin <= 1'b0;
            repeat (4) @(posedge i_clk);
            if (n_cal != seen) begin
                seen = n_cal;
                prev = last;
                last = k;
            end
        end
        g = last - prev;
    endtask

    // Main sequence
    initial begin
        i_reset = 1'b1;
        i_awvalid = 1'b0;
        i_wvalid = 1'b0;
        i_bready = 1'b0;
        i_arvalid = 1'b0;
        i_rready = 1'b0;
        i_awaddr = 8'h00;
        i_araddr = 8'h00;
        i_wdata = 32'h0;
        i_wstrb = 4'hf;
        i_ref_pin = 1'b0;
        i_fb_pin = 1'b0;
        void'($urandom(51));
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(8'h18, 32'h06, 2'h0, "ctrl reset");
        rd(8'h1c, 32'h0, 2'h0, "status reset");
        rd(8'h20, 32'h0, 2'h0, "irq status reset");
        rd(8'h28, 32'h0, 2'h0, "irq clear reads");
        rd(8'h00, 32'h0, 2'h2, "unmapped read");
        wr(8'h04, 32'hff, 2'h2);
        wr(8'h1c, 32'hff, 2'h0);
        rd(8'h1c, 32'h0, 2'h0, "status after write");
        wr(8'h24, 32'hffffffff, 2'h0);
        rd(8'h24, 32'h7, 2'h0, "irq enable");
        // A write without the low byte strobe must leave the register alone
        i_wstrb <= 4'he;
        wr(8'h24, 32'h0, 2'h0);
        i_wstrb <= 4'hf;
        rd(8'h24, 32'h7, 2'h0, "irq enable kept");
        $display("test registers done");
        // Broken runs, window edge, hysteresis and lock interrupts
        wr(8'h28, 32'h7, 2'h0);
        wr(8'h24, 32'h1, 2'h0);
        repeat (5) pair(6);
        lock_is(1'b0, "lock at window edge");
        goods(4, 6);
        pair($urandom_range(12, 6));
        goods(4, 6);
        lock_is(1'b0, "lock after broken run");
        chk("irq before lock", 32'h0, 32'(o_irq));
        goods(1, 6);
        lock_is(1'b1, "lock after run");
        chk("irq on lock", 32'h1, 32'(o_irq));
        pair(12);
        pair(6);
        pair(-12);
        lock_is(1'b1, "lock inside loss limit");
        pair($urandom_range(40, 13));
        lock_is(1'b0, "lock lost");
        rd(8'h20, 32'h3, 2'h0, "lock events");
        wr(8'h28, 32'h1, 2'h0);
        repeat (2) @(posedge i_clk);
        chk("irq masked", 32'h0, 32'(o_irq));
        rd(8'h20, 32'h2, 2'h0, "events after clear");
        $display("test hysteresis done");
        // Every count select, one cycle short then exact
        for (int s = 0; s < 4; s++) begin
            wr(8'h18, 32'(s << 5) | 32'h6, 2'h0);
            pair(30);
            goods(need_tab[s] - 1, 6);
            lock_is(1'b0, "lock one short");
            goods(1, 6);
            lock_is(1'b1, "lock at count");
            rd(8'h1c, 32'(need_tab[s] << 8) | 32'h1, 2'h0, "status");
        end
        $display("test count select done");
        // Low window range
        wr(8'h18, 32'h16, 2'h0);
        pair(30);
        repeat (5) pair(3);
        lock_is(1'b0, "low window edge");
        goods(5, 3);
        lock_is(1'b1, "low window lock");
        pair(6);
        lock_is(1'b1, "low loss limit");
        pair(7);
        lock_is(1'b0, "low loss");
        $display("test window range done");
        // Disable while locked, then enable again
        wr(8'h18, 32'h06, 2'h0);
        pair(30);
        goods(5, 6);
        lock_is(1'b1, "lock before disable");
        wr(8'h18, 32'h0e, 2'h0);
        lock_is(1'b0, "lock on disable");
        goods(6, 6);
        lock_is(1'b0, "lock while disabled");
        wr(8'h18, 32'h06, 2'h0);
        goods(5, 6);
        lock_is(1'b1, "lock re-enabled");
        $display("test disable done");
        // Each divider code
        for (int c = 0; c < 4; c++) begin
            wr(8'h18, 32'(c << 1), 2'h0);
            cal_gap(2 << c, gap);
            chk("cal divide", 32'(2 << c), 32'(gap));
        end
        // Lone reference edges give wide cycles, so the earlier lock is gone
        chk("lock after lone edges", 32'h0, 32'(o_digital_lock_indicator));
        $display("test cal divider done");
        // Start only on a 0 to 1 change of the start bit
        wr(8'h28, 32'h7, 2'h0);
        wr(8'h24, 32'h4, 2'h0);
        s0 = n_start;
        wr(8'h18, 32'h07, 2'h0);
        repeat (2) @(posedge i_clk);
        chk("start pulse", 32'(s0 + 1), 32'(n_start));
        chk("irq on start", 32'h1, 32'(o_irq));
        wr(8'h18, 32'h07, 2'h0);
        repeat (2) @(posedge i_clk);
        chk("no start on 1", 32'(s0 + 1), 32'(n_start));
        rd(8'h20, 32'h4, 2'h0, "start event");
        wr(8'h28, 32'h4, 2'h0);
        repeat (2) @(posedge i_clk);
        chk("irq cleared", 32'h0, 32'(o_irq));
        $display("test cal start done");
        wrap_up();
    end
endmodule
`default_nettype wire
